// ---- hw/dhs_status_flags.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - match status bits 0-3 latch four recognizer pairs until reset; 4-7 read zero
// - address flag sets on valid or end of address; mode three bit 0 enables
// - end of receive packet sets on closing flag; mode one bit 3 enables
// - status one bits 0,1 clear on status one or byte count read
// - reception in progress sets byte after opening flag, clears on flag/abort
// - bits 3,4 are live loopback indications, device and line interface
// - bit 5 reads one while back-off is not active
// - transmit end sets on closing flag sent; clears on read or count load
// - transmit abort sets after abort sent; clears on read or count load
// - idle mode clears both status registers; reset clears status one and loads 10h into status two
// - last received byte flag sets on final byte read; clears on read
// - receive byte available is live buffer not empty
// - packet lost sets on third unserviced packet; clears on read
// - last byte transmitted sets on final byte leaving; clears on read
// - transmit buffer available is live not full
// - mark idle follows fifteen ones detection, clears on zero
// - flag idle sets on over two flags, clears on non-flag
// - second packet bit is live; extended fifo bit 1 enables
// - status two reads 10h after reset
// - mode three bits 0 and 1 default to enabled
module dhs_status_flags
	import dhs_pkg::*;
(
	// clock, reset, enable
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	// register read port
	input  wire logic       rd_i,
	input  wire logic [7:0] rd_idx_i,
	input  wire logic       rx_count_rd_i,
	input  wire logic       tx_count_load_i,
	output logic      [7:0] rd_data_o,
	// mode register bits
	input  wire logic [7:0] mode_one_i,
	input  wire logic [7:0] mode_three_i,
	input  wire logic [7:0] ext_fifo_ctrl_i,
	input  wire logic       idle_mode_i,
	// datapath events
	input  wire logic [3:0] addr_match_i,
	input  wire logic       addr_done_i,
	input  wire logic       rx_close_flag_i,
	input  wire logic       rx_open_byte_i,
	input  wire logic       rx_flag_or_abort_i,
	input  wire logic       loop_dev_i,
	input  wire logic       loop_liu_i,
	input  wire logic       backoff_i,
	input  wire logic       tx_close_flag_i,
	input  wire logic       tx_abort_sent_i,
	input  wire logic       rx_last_read_i,
	input  wire logic       rx_buf_nempty_i,
	input  wire logic       rx_pkt_lost_i,
	input  wire logic       tx_last_out_i,
	input  wire logic       tx_buf_nfull_i,
	input  wire logic       mark_idle_i,
	input  wire logic       flag_idle_set_i,
	input  wire logic       non_flag_i,
	input  wire logic       second_pkt_i,
	// interrupt
	output logic            irq_o
);
	// ==========================================================
	// read decode
	wire rd_match = rd_i && rd_idx_i == ADDR_MATCH_STATUS_IDX;
	wire rd_one   = rd_i && rd_idx_i == DCHAN_STATUS_ONE_IDX;
	wire rd_two   = rd_i && rd_idx_i == DCHAN_STATUS_TWO_IDX;
	wire clr_one_rx = rd_one || rx_count_rd_i;
	wire clr_one_tx = rd_one || tx_count_load_i;
	logic [3:0] match_reg;
	logic [7:0] one_reg;
	logic [7:0] two_reg;
	logic [7:0] one_next;
	logic [7:0] two_next;
	logic [3:0] match_next;
	logic [7:0] rd_data_next;
	logic       irq_next;
	// ==========================================================
	// next values; set wins over clear, idle mode clears over both
	always_comb begin
		match_next = match_reg | addr_match_i;
		one_next = one_reg;
		two_next = two_reg;
		if (clr_one_rx) begin
			one_next[S1_ADDR] = 1'b0;
			one_next[S1_EOP] = 1'b0;
		end
		if (addr_done_i) begin
			one_next[S1_ADDR] = 1'b1;
		end
		if (rx_close_flag_i) begin
			one_next[S1_EOP] = 1'b1;
		end
		if (rx_flag_or_abort_i) begin
			one_next[S1_RXPROG] = 1'b0;
		end
		if (rx_open_byte_i) begin
			one_next[S1_RXPROG] = 1'b1;
		end
		one_next[S1_LBDEV] = loop_dev_i;
		one_next[S1_LBLIU] = loop_liu_i;
		one_next[S1_NOBOFF] = ~backoff_i;
		if (clr_one_tx) begin
			one_next[S1_TXEND] = 1'b0;
			one_next[S1_TXABT] = 1'b0;
		end
		if (tx_close_flag_i) begin
			one_next[S1_TXEND] = 1'b1;
		end
		if (tx_abort_sent_i) begin
			one_next[S1_TXABT] = 1'b1;
		end
		if (rd_two) begin
			two_next[S2_LASTRX] = 1'b0;
			two_next[S2_LOST] = 1'b0;
			two_next[S2_LASTTX] = 1'b0;
		end
		if (rx_last_read_i) begin
			two_next[S2_LASTRX] = 1'b1;
		end
		if (rx_pkt_lost_i) begin
			two_next[S2_LOST] = 1'b1;
		end
		if (tx_last_out_i) begin
			two_next[S2_LASTTX] = 1'b1;
		end
		two_next[S2_RXAVL] = rx_buf_nempty_i;
		two_next[S2_TXAVL] = tx_buf_nfull_i;
		two_next[S2_MARK] = mark_idle_i;
		if (non_flag_i) begin
			two_next[S2_FLAG] = 1'b0;
		end
		if (flag_idle_set_i) begin
			two_next[S2_FLAG] = 1'b1;
		end
		two_next[S2_SECOND] = second_pkt_i;
		if (idle_mode_i) begin
			one_next = STATUS_ONE_RST;
			two_next = '0;
		end
	end
	// ==========================================================
	// read mux and interrupt
	wire [7:0] match_word = {4'h0, match_reg};
	assign rd_data_next = rd_match ? match_word :
		rd_one ? one_reg : rd_two ? two_reg : 8'h00;
	assign irq_next =
		(one_next[S1_ADDR] && mode_three_i[M3_ADDR_IE]) ||
		(one_next[S1_EOP] && mode_one_i[M1_EOP_IE]) ||
		(one_next[S1_TXEND] && mode_three_i[M3_TXEND_IE]) ||
		(two_next[S2_LASTRX] && mode_three_i[M3_LASTRX_IE]) ||
		(two_next[S2_RXAVL] && mode_one_i[M1_EOP_IE]) ||
		(two_next[S2_LOST] && mode_three_i[M3_LOST_IE]) ||
		(two_next[S2_LASTTX] && mode_three_i[M3_LASTTX_IE]) ||
		(two_next[S2_TXAVL] && mode_three_i[M3_TXAVL_IE]) ||
		(two_next[S2_SECOND] && ext_fifo_ctrl_i[EF_SECOND_IE]);
	// ==========================================================
	// registers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			match_reg <= MATCH_RST;
			one_reg   <= STATUS_ONE_RST;
			two_reg   <= STATUS_TWO_RST;
			rd_data_o <= 8'h00;
			irq_o     <= 1'b0;
		end else if (clk_en_i) begin
			match_reg <= match_next;
			one_reg   <= one_next;
			two_reg   <= two_next;
			rd_data_o <= rd_data_next;
			irq_o     <= irq_next;
		end
	end
endmodule // dhs_status_flags

// ---- pkg/dhs_pkg.sv ----
package dhs_pkg;
	// ==========================================================
	// register indices
	localparam logic [7:0] ADDR_MATCH_STATUS_IDX = 8'h91;
	localparam logic [7:0] DCHAN_STATUS_ONE_IDX  = 8'ha0;
	localparam logic [7:0] DCHAN_STATUS_TWO_IDX  = 8'ha1;
	// ==========================================================
	// reset values
	localparam logic [7:0] STATUS_ONE_RST = 8'h00;
	localparam logic [7:0] STATUS_TWO_RST = 8'h10;
	localparam logic [3:0] MATCH_RST      = 4'h0;
	// ==========================================================
	// field positions
	localparam int S1_ADDR   = 0;
	localparam int S1_EOP    = 1;
	localparam int S1_RXPROG = 2;
	localparam int S1_LBDEV  = 3;
	localparam int S1_LBLIU  = 4;
	localparam int S1_NOBOFF = 5;
	localparam int S1_TXEND  = 6;
	localparam int S1_TXABT  = 7;
	localparam int S2_LASTRX = 0;
	localparam int S2_RXAVL  = 1;
	localparam int S2_LOST   = 2;
	localparam int S2_LASTTX = 3;
	localparam int S2_TXAVL  = 4;
	localparam int S2_MARK   = 5;
	localparam int S2_FLAG   = 6;
	localparam int S2_SECOND = 7;
	localparam int M1_EOP_IE = 3;
	localparam int M3_ADDR_IE   = 0;
	localparam int M3_TXEND_IE  = 1;
	localparam int M3_LASTRX_IE = 2;
	localparam int M3_RXAVL_IE  = 3;
	localparam int M3_LASTTX_IE = 4;
	localparam int M3_TXAVL_IE  = 5;
	localparam int M3_LOST_IE   = 6;
	localparam int EF_SECOND_IE = 1;
endpackage

// ---- dv/dhs_cpu_model.sv ----
`timescale 1ns/1ps
// ==========
// processor read side
module dhs_cpu_model (
	input  wire logic       core_clk_i,
	output logic            rd_o,
	output logic      [7:0] idx_o
);
	initial rd_o = 1'b0;
	initial idx_o = 8'h00;
	// one-cycle read, index scrambled after release
	// fifo thresholds never written here
	task automatic rd(input logic [7:0] i);
		@(negedge core_clk_i);
		rd_o = 1'b1;
		idx_o = i;
		@(negedge core_clk_i);
		rd_o = 1'b0;
		idx_o = ~i;
	endtask
endmodule // dhs_cpu_model

// ---- dv/dhs_status_flags_chk.sv ----
`timescale 1ns/1ps
// ==========
// flag checks
module dhs_status_flags_chk (
	input wire logic       core_clk_i, rst_i, clk_en_i, rd_i, idle_mode_i,
	input wire logic       addr_done_i, rx_close_flag_i, tx_buf_nfull_i,
	input wire logic       irq_o,
	input wire logic [3:0] addr_match_i,
	input wire logic [7:0] rd_idx_i, rd_data_o, mode_one_i, mode_three_i,
	input wire logic [7:0] ext_fifo_ctrl_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i || !clk_en_i);
	sequence s_r1; rd_i && rd_idx_i == 8'ha0; endsequence
	sequence s_gap; !rd_i && !idle_mode_i; endsequence
	property p_va;
		addr_done_i && !idle_mode_i ##1 s_gap ##1 s_r1 |=> rd_data_o[0];
	endproperty
	a_va: assert property (p_va) else $error("no addr flag");
	property p_eop;
		rx_close_flag_i && !idle_mode_i ##1 s_gap ##1 s_r1 |=> rd_data_o[1];
	endproperty
	a_eop: assert property (p_eop) else $error("no eop flag");
	property p_clr;
		(s_r1 and !addr_done_i) ##1 (s_gap and !addr_done_i) ##1 s_r1
			|=> !rd_data_o[0];
	endproperty
	a_clr: assert property (p_clr) else $error("no read clear");
	property p_idle;
		idle_mode_i ##1 (s_r1 and idle_mode_i)
			|=> {rd_data_o[7:6], rd_data_o[2:0]} == 5'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("idle kept");
	property p_irq;
		addr_done_i && mode_three_i[0] && !idle_mode_i |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("no irq");
	property p_mask;
		!mode_one_i[3] && mode_three_i[6:0] == 7'h00 && !ext_fifo_ctrl_i[1]
			|=> !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	property p_tx;
		(tx_buf_nfull_i && !idle_mode_i) [*2] ##1 rd_i && rd_idx_i == 8'ha1
			|=> rd_data_o[4];
	endproperty
	a_tx: assert property (p_tx) else $error("no tx avail");
	property p_asr;
		addr_match_i[2] ##2 rd_i && rd_idx_i == 8'h91 |=> rd_data_o[2];
	endproperty
	a_asr: assert property (p_asr) else $error("no match bit");
endmodule // dhs_status_flags_chk
bind dhs_status_flags dhs_status_flags_chk u_chk (.core_clk_i, .rst_i,
	.clk_en_i, .rd_i, .idle_mode_i, .addr_done_i, .rx_close_flag_i,
	.tx_buf_nfull_i, .irq_o, .addr_match_i, .rd_idx_i, .rd_data_o,
	.mode_one_i, .mode_three_i, .ext_fifo_ctrl_i);

// ---- dv/dhs_status_flags_tb.sv ----
`timescale 1ns/1ps
// ==========
// status flag bench
module dhs_status_flags_tb;
	logic        clk, rst, en, idle, rd, irq, pend;
	logic [7:0]  idx, m1, m3, ef, rdat, q[$];
	logic [3:0]  am;
	logic [12:0] ev;
	logic [6:0]  lv;
	int          err_count = 0, compares = 0, cyc = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	dhs_cpu_model u_dhs_cpu_model (.core_clk_i(clk), .rd_o(rd), .idx_o(idx));
	dhs_status_flags u_dhs_status_flags (.core_clk_i(clk), .rst_i(rst),
		.clk_en_i(en), .rd_i(rd), .rd_idx_i(idx), .rx_count_rd_i(ev[11]),
		.tx_count_load_i(ev[12]), .rd_data_o(rdat), .mode_one_i(m1),
		.mode_three_i(m3), .ext_fifo_ctrl_i(ef), .idle_mode_i(idle),
		.addr_match_i(am), .addr_done_i(ev[0]), .rx_close_flag_i(ev[1]),
		.rx_open_byte_i(ev[2]), .rx_flag_or_abort_i(ev[3]),
		.loop_dev_i(lv[0]), .loop_liu_i(lv[1]), .backoff_i(lv[2]),
		.tx_close_flag_i(ev[4]), .tx_abort_sent_i(ev[5]),
		.rx_last_read_i(ev[6]), .rx_buf_nempty_i(lv[3]),
		.rx_pkt_lost_i(ev[7]), .tx_last_out_i(ev[8]), .tx_buf_nfull_i(lv[4]),
		.mark_idle_i(lv[5]), .flag_idle_set_i(ev[9]), .non_flag_i(ev[10]),
		.second_pkt_i(lv[6]), .irq_o(irq));
	task automatic check(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdx(input logic [7:0] i, e);
		q.push_back(e);
		u_dhs_cpu_model.rd(i);
	endtask
	task automatic pulse(input logic [12:0] v);
		@(negedge clk);
		ev = v;
		@(negedge clk);
		ev = '0;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		pend <= rd & en & ~rst;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			test_done;
		end
	end
	always @(negedge clk) if (pend) check(rdat, q.pop_front());
	initial begin
		void'($urandom(36777));
		{idle, m1, ef, am, ev} = '0;
		{rst, en, m3, lv} = {2'b11, 8'h03, 7'h14};
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rdx(8'h91, 8'h00);
		rdx(8'ha1, 8'h10);
		rdx(8'h55, 8'h00);
		repeat (4) begin
			lv = 7'($urandom);
			@(negedge clk);
			rdx(8'ha0, {2'b00, ~lv[2], lv[1:0], 3'b000});
			rdx(8'ha1, {lv[6], 1'b0, lv[5:4], 2'b00, lv[3], 1'b0});
		end
		$display("test levels done");
		{lv, am} = {7'h04, 4'h5};
		@(negedge clk);
		am = 4'h0;
		rdx(8'h91, 8'h05);
		pulse(13'h0037);
		check({7'h00, irq}, 8'h01);
		rdx(8'ha0, 8'hc7);
		rdx(8'ha0, 8'h04);
		check({7'h00, irq}, 8'h00);
		pulse(13'h0008);
		rdx(8'ha0, 8'h00);
		pulse(13'h0002);
		pulse(13'h0800);
		rdx(8'ha0, 8'h00);
		pulse(13'h0030);
		pulse(13'h1000);
		rdx(8'ha0, 8'h00);
		pulse(13'h03c0);
		rdx(8'ha1, 8'h4d);
		rdx(8'ha1, 8'h40);
		pulse(13'h0400);
		rdx(8'ha1, 8'h00);
		$display("test events done");
		pulse(13'h03f7);
		idle = 1'b1;
		rdx(8'ha0, 8'h00);
		rdx(8'ha1, 8'h00);
		{idle, en} = 2'b00;
		pulse(13'h0001);
		en = 1'b1;
		rdx(8'ha0, 8'h00);
		m3 = 8'h00;
		pulse(13'h0001);
		check({7'h00, irq}, 8'h00);
		$display("test idle done");
		repeat (3) @(negedge clk);
		test_done;
	end
endmodule // dhs_status_flags_tb
